//--- hw/fsm_pkg.sv
// Package of constants and types shared by the flash security control ends.
package fsm_pkg;
   // ****************************************************************
   // Register offsets and field layout.
   // ****************************************************************
   localparam logic [2:0] FSM_OFF_CNFG = 3'h0;
   localparam logic [2:0] FSM_OFF_SECURITY = 3'h1;
   localparam logic [2:0] FSM_OFF_PROT = 3'h2;
   localparam logic [2:0] FSM_OFF_STAT = 3'h3;
   localparam logic [2:0] FSM_OFF_CMD = 3'h4;
   localparam int FSM_CNFG_BE_IRQ = 7;
   localparam int FSM_CNFG_CC_IRQ = 6;
   localparam int FSM_CNFG_KACC = 5;
   localparam int FSM_STAT_CBE = 7;
   localparam int FSM_STAT_CC = 6;
   localparam int FSM_STAT_AERR = 4;
   localparam logic [1:0] FSM_KEY_ENABLED = 2'h2;
   localparam logic [1:0] FSM_SECURITY_OPEN = 2'h2;
   localparam int FSM_SECURITY_KEY_LSB = 6;
   localparam int FSM_SECURITY_STATE_LSB = 0;
   // ****************************************************************
   // Array addresses, commands and timing.
   // ****************************************************************
   localparam logic [15:0] FSM_ADDR_KEY0 = 16'hFF00;
   localparam logic [15:0] FSM_ADDR_SECURITY = 16'hFF0F;
   localparam logic [15:0] FSM_ADDR_PROT = 16'hFF0D;
   localparam logic [15:0] FSM_KEY_ZERO = 16'h0000;
   localparam logic [15:0] FSM_KEY_ONES = 16'hFFFF;
   localparam logic [15:0] FSM_BAD_DATA = 16'hFFFF;
   localparam logic [7:0] FSM_CMD_MASS = 8'h41;
   localparam logic [7:0] FSM_CMD_NONE = 8'h00;
   localparam int FSM_CMD_CYCLES = 16;
   localparam logic [1:0] FSM_KEY_LAST = 2'h3;
   typedef enum logic [2:0] {
      FSM_ST_LOAD_PROT = 3'h0,
      FSM_ST_LOAD_SECURITY = 3'h1,
      FSM_ST_IDLE = 3'h2,
      FSM_ST_BUSY = 3'h3,
      FSM_ST_STOP = 3'h4
   } fsm_state_e;
   typedef enum logic [1:0] {
      FSM_KS_IDLE = 2'h0,
      FSM_KS_RUN = 2'h1,
      FSM_KS_LOCK = 2'h2
   } fsm_key_e;
endpackage

//--- hw/fsm_if.sv
// Interface joining the CPU side and the flash control end.
`timescale 1ns/1ps
interface fsm_if;
   logic reg_wr;
   logic reg_rd;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic arr_wr;
   logic arr_rd;
   logic [15:0] arr_addr;
   logic [15:0] arr_wdata;
   logic [15:0] arr_rdata;
   logic stop_mode;
   logic debug_mode;
   logic special_single_chip;
   logic cpu_stall;
   logic irq;
   modport dev (
      input reg_wr, reg_rd, reg_addr, reg_wdata, arr_wr, arr_rd,
      input arr_addr, arr_wdata, stop_mode, debug_mode, special_single_chip,
      output reg_rdata, arr_rdata, cpu_stall, irq
   );
   modport cpu (
      output reg_wr, reg_rd, reg_addr, reg_wdata, arr_wr, arr_rd,
      output arr_addr, arr_wdata, stop_mode, debug_mode, special_single_chip,
      input reg_rdata, arr_rdata, cpu_stall, irq
   );
endinterface

//--- hw/fsm_flash_ctrl.sv
// Flash security, mode and interrupt control end.
`timescale 1ns/1ps
module fsm_flash_ctrl #(
   parameter int CMD_CYCLES = fsm_pkg::FSM_CMD_CYCLES,
   parameter logic [15:0] KEY_W0 = 16'h1234,
   parameter logic [15:0] KEY_W1 = 16'h5678,
   parameter logic [15:0] KEY_W2 = 16'h9ABC,
   parameter logic [15:0] KEY_W3 = 16'hDEF1,
   parameter logic [7:0] STORED_SECURITY = 8'h80,
   parameter logic [7:0] STORED_PROT = 8'hFF
) (
   input wire logic mclk,
   input wire logic rst_n,
   fsm_if.dev bus
);
   import fsm_pkg::*;
   // ****************************************************************
   // State.
   // ****************************************************************
   fsm_state_e st_r;
   fsm_key_e ks_r;
   logic [7:0] cnfg_r;
   logic [7:0] security_r;
   logic [7:0] prot_r;
   logic cbe_r, cc_r, aerr_r;
   logic [7:0] cmd_r;
   logic cmd_ok_r;
   logic [15:0] cnt_r;
   logic [1:0] kidx_r;
   logic kfull_r;
   logic [7:0] rdata_r;
   logic [15:0] adata_r;
   logic stall_r, irq_r;
   logic stop_q_r;
   logic [15:0] key_exp;
   logic secured, kacc, reg_cnfg_w, reg_prot_w, reg_stat_w, reg_cmd_w;
   logic launch, stop_entry, stop_exit, key_wr, key_word_ok, cmd_allowed;
   logic [15:0] nxt_cnt;
   // ****************************************************************
   // Decoding.
   // ****************************************************************
   assign secured = security_r[FSM_SECURITY_STATE_LSB +: 2]
      != FSM_SECURITY_OPEN;
   assign kacc = cnfg_r[FSM_CNFG_KACC];
   assign reg_cnfg_w = bus.reg_wr && bus.reg_addr == FSM_OFF_CNFG;
   assign reg_prot_w = bus.reg_wr && bus.reg_addr == FSM_OFF_PROT
      && bus.debug_mode;
   assign reg_stat_w = bus.reg_wr && bus.reg_addr == FSM_OFF_STAT;
   assign reg_cmd_w = bus.reg_wr && bus.reg_addr == FSM_OFF_CMD;
   assign cmd_allowed = !(secured && bus.special_single_chip)
      || bus.reg_wdata == FSM_CMD_MASS;
   assign launch = reg_stat_w && bus.reg_wdata[FSM_STAT_CBE] && cbe_r
      && !aerr_r && st_r == FSM_ST_IDLE && cmd_ok_r;
   assign stop_entry = bus.stop_mode && !stop_q_r;
   assign stop_exit = !bus.stop_mode && stop_q_r;
   assign key_wr = bus.arr_wr && kacc
      && security_r[FSM_SECURITY_KEY_LSB +: 2] == FSM_KEY_ENABLED;
   assign key_exp = kidx_r == 2'h0 ? KEY_W0 : kidx_r == 2'h1 ? KEY_W1 :
      kidx_r == 2'h2 ? KEY_W2 : KEY_W3;
   assign key_word_ok = bus.arr_addr == FSM_ADDR_KEY0 + {13'h0, kidx_r, 1'b0}
      && bus.arr_wdata == key_exp && bus.arr_wdata != FSM_KEY_ZERO
      && bus.arr_wdata != FSM_KEY_ONES && ks_r != FSM_KS_LOCK
      && !(bus.debug_mode && bus.special_single_chip);
   assign nxt_cnt = cnt_r - 16'h1;
   // ****************************************************************
   // Reset load and command sequencing.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r <= FSM_ST_LOAD_PROT;
         stall_r <= 1'b1;
         security_r <= 8'h00;
         prot_r <= 8'h00;
         cbe_r <= 1'b1;
         cc_r <= 1'b1;
         aerr_r <= 1'b0;
         cmd_r <= FSM_CMD_NONE;
         cmd_ok_r <= 1'b0;
         cnt_r <= 16'h0;
         stop_q_r <= 1'b0;
      end else begin
         stop_q_r <= bus.stop_mode;
         if (reg_prot_w) begin
            prot_r <= bus.reg_wdata;
         end
         if (reg_stat_w && bus.reg_wdata[FSM_STAT_AERR]) begin
            aerr_r <= 1'b0;
         end
         if (reg_cmd_w && cbe_r && !aerr_r) begin
            cmd_r <= bus.reg_wdata;
            cmd_ok_r <= cmd_allowed;
            if (!cmd_allowed) begin
               aerr_r <= 1'b1;
            end
         end
         case (st_r)
            FSM_ST_LOAD_PROT: begin
               prot_r <= STORED_PROT;
               st_r <= FSM_ST_LOAD_SECURITY;
            end
            FSM_ST_LOAD_SECURITY: begin
               security_r <= STORED_SECURITY;
               stall_r <= 1'b0;
               st_r <= FSM_ST_IDLE;
            end
            FSM_ST_IDLE: begin
               if (launch) begin
                  cbe_r <= 1'b0;
                  cc_r <= 1'b0;
                  cmd_ok_r <= 1'b0;
                  cnt_r <= 16'(CMD_CYCLES);
                  st_r <= FSM_ST_BUSY;
               end
               if (stop_entry) begin
                  st_r <= FSM_ST_STOP;
                  if (launch) begin
                     cc_r <= 1'b1;
                     aerr_r <= 1'b1;
                  end
               end
            end
            FSM_ST_BUSY: begin
               cnt_r <= nxt_cnt;
               if (cnt_r == 16'h1) begin
                  cbe_r <= 1'b1;
                  cc_r <= 1'b1;
                  st_r <= FSM_ST_IDLE;
               end
               if (stop_entry) begin
                  cc_r <= 1'b1;
                  aerr_r <= 1'b1;
                  st_r <= FSM_ST_STOP;
               end
            end
            FSM_ST_STOP: begin
               if (stop_exit) begin
                  cbe_r <= 1'b1;
                  cmd_ok_r <= 1'b0;
                  st_r <= FSM_ST_IDLE;
               end
            end
            default: st_r <= FSM_ST_IDLE;
         endcase
         if (ks_r == FSM_KS_RUN && kfull_r && !kacc
               && st_r != FSM_ST_LOAD_SECURITY) begin
            security_r[FSM_SECURITY_STATE_LSB +: 2]
               <= FSM_SECURITY_OPEN;
         end
      end
   end
   // ****************************************************************
   // Backdoor key machine and configuration.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ks_r <= FSM_KS_IDLE;
         kidx_r <= 2'h0;
         kfull_r <= 1'b0;
         cnfg_r <= 8'h00;
      end else begin
         if (reg_cnfg_w) begin
            cnfg_r <= bus.reg_wdata;
         end
         case (ks_r)
            FSM_KS_IDLE: begin
               if (key_wr) begin
                  ks_r <= key_word_ok ? FSM_KS_RUN : FSM_KS_LOCK;
                  kidx_r <= 2'h1;
               end
            end
            FSM_KS_RUN: begin
               if (key_wr) begin
                  if (kfull_r || !key_word_ok) begin
                     ks_r <= FSM_KS_LOCK;
                  end else if (kidx_r == FSM_KEY_LAST) begin
                     kfull_r <= 1'b1;
                  end else begin
                     kidx_r <= kidx_r + 2'h1;
                  end
               end else if (!kacc) begin
                  ks_r <= kfull_r ? FSM_KS_IDLE : FSM_KS_LOCK;
                  kidx_r <= 2'h0;
                  kfull_r <= 1'b0;
               end
            end
            FSM_KS_LOCK: ks_r <= FSM_KS_LOCK;
            default: ks_r <= FSM_KS_LOCK;
         endcase
      end
   end
   // ****************************************************************
   // Read data and interrupt.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
         adata_r <= 16'h0;
         irq_r <= 1'b0;
      end else begin
         case (bus.reg_addr)
            FSM_OFF_CNFG: rdata_r <= cnfg_r;
            FSM_OFF_SECURITY: rdata_r <= security_r;
            FSM_OFF_PROT: rdata_r <= prot_r;
            FSM_OFF_STAT: rdata_r <= {cbe_r, cc_r, 1'b0, aerr_r, 4'h0};
            FSM_OFF_CMD: rdata_r <= cmd_r;
            default: rdata_r <= 8'h00;
         endcase
         adata_r <= (kacc || st_r == FSM_ST_BUSY) ? FSM_BAD_DATA :
            bus.arr_addr;
         irq_r <= (cbe_r && cnfg_r[FSM_CNFG_BE_IRQ])
            || (cc_r && cnfg_r[FSM_CNFG_CC_IRQ]);
      end
   end
   assign bus.reg_rdata = rdata_r;
   assign bus.arr_rdata = adata_r;
   assign bus.cpu_stall = stall_r;
   assign bus.irq = irq_r;
endmodule // fsm_flash_ctrl

//--- hw/fsm_cpu_end.sv
// CPU-side end that drives register and array requests.
`timescale 1ns/1ps
module fsm_cpu_end (
   input wire logic mclk,
   input wire logic rst_n,
   fsm_if.cpu bus,
   input wire logic req_reg_wr,
   input wire logic req_reg_rd,
   input wire logic [2:0] req_reg_addr,
   input wire logic [7:0] req_reg_wdata,
   input wire logic req_arr_wr,
   input wire logic req_arr_rd,
   input wire logic [15:0] req_arr_addr,
   input wire logic [15:0] req_arr_wdata,
   input wire logic req_stop,
   input wire logic req_debug,
   input wire logic req_ssc,
   output logic [7:0] rsp_reg_rdata,
   output logic [15:0] rsp_arr_rdata,
   output logic rsp_irq,
   output logic rsp_stalled
);
   import fsm_pkg::*;
   logic go;
   assign go = !bus.cpu_stall;
   // ****************************************************************
   // Requests held back while the flash stalls the CPU.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bus.reg_wr <= 1'b0;
         bus.reg_rd <= 1'b0;
         bus.reg_addr <= FSM_OFF_CNFG;
         bus.reg_wdata <= 8'h00;
         bus.arr_wr <= 1'b0;
         bus.arr_rd <= 1'b0;
         bus.arr_addr <= 16'h0;
         bus.arr_wdata <= 16'h0;
         bus.stop_mode <= 1'b0;
         bus.debug_mode <= 1'b0;
         bus.special_single_chip <= 1'b0;
         rsp_reg_rdata <= 8'h00;
         rsp_arr_rdata <= 16'h0;
         rsp_irq <= 1'b0;
         rsp_stalled <= 1'b1;
      end else begin
         bus.reg_wr <= req_reg_wr && go;
         bus.reg_rd <= req_reg_rd && go;
         bus.reg_addr <= req_reg_addr;
         bus.reg_wdata <= req_reg_wdata;
         bus.arr_wr <= req_arr_wr && go;
         bus.arr_rd <= req_arr_rd && go;
         bus.arr_addr <= req_arr_addr;
         bus.arr_wdata <= req_arr_wdata;
         bus.stop_mode <= req_stop;
         bus.debug_mode <= req_debug;
         bus.special_single_chip <= req_ssc;
         rsp_reg_rdata <= bus.reg_rdata;
         rsp_arr_rdata <= bus.arr_rdata;
         rsp_irq <= bus.irq;
         rsp_stalled <= bus.cpu_stall;
      end
   end
endmodule // fsm_cpu_end

//--- dv/fsm_checker.sv
// Assertion checker for the flash security control interface.
`timescale 1ns/1ps
module fsm_checker
   import fsm_pkg::*;
#(
   parameter logic [7:0] STORED_PROT = 8'hFF
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic arr_wr,
   input wire logic arr_rd,
   input wire logic [15:0] arr_rdata,
   input wire logic stop_mode,
   input wire logic debug_mode,
   input wire logic cpu_stall,
   input wire logic irq
);
   // ****************************************************************
   // Shadow registers and properties.
   // ****************************************************************
   logic [7:0] cnfg_r;
   logic [7:0] prot_r;
   wire cnfg_wr = reg_wr && reg_addr == FSM_OFF_CNFG;
   wire prot_wr = reg_wr && reg_addr == FSM_OFF_PROT && debug_mode;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnfg_r <= 8'h00;
         prot_r <= STORED_PROT;
      end else begin
         if (cnfg_wr) cnfg_r <= reg_wdata;
         if (prot_wr) prot_r <= reg_wdata;
      end
   end
   stall_release_a: assert property (
      $rose(rst_n) |-> cpu_stall ##[1:3] !cpu_stall)
      else $error("cpu stall not released after reset load");
   stall_stays_a: assert property (!cpu_stall |=> !cpu_stall)
      else $error("cpu stall raised outside reset");
   no_wr_stall_a: assert property (
      cpu_stall |-> !reg_wr && !arr_wr)
      else $error("write issued while cpu stalled");
   irq_quiet_a: assert property ($rose(rst_n) |-> !irq)
      else $error("interrupt high at reset release");
   irq_off_a: assert property (
      cnfg_r[7:6] == 2'h0 && $past(cnfg_r[7:6]) == 2'h0 |-> !irq)
      else $error("interrupt high with both enables clear");
   key_access_bit_read_a: assert property (
      arr_rd && cnfg_r[FSM_CNFG_KACC] |=> arr_rdata == FSM_BAD_DATA)
      else $error("array read valid while key access set");
   stop_entry_a: assert property (
      $rose(stop_mode) && cnfg_r[FSM_CNFG_CC_IRQ] |-> ##[1:4] irq)
      else $error("no complete interrupt after stop entry");
   stop_exit_a: assert property (
      $fell(stop_mode) && cnfg_r[FSM_CNFG_BE_IRQ] |-> ##[1:4] irq)
      else $error("no buffer empty interrupt after stop exit");
   prot_read_a: assert property (
      reg_rd && reg_addr == FSM_OFF_PROT |=> reg_rdata == $past(prot_r))
      else $error("protection register read mismatch");
endmodule // fsm_checker

//--- dv/flash_security_and_mode_control_tb.sv
// Self-checking bench for the flash security control pair.
`timescale 1ns/1ps
module flash_security_and_mode_control_tb;
   import fsm_pkg::*;
   localparam int CYC = 20;
   localparam logic [63:0] KEYS = 64'hDEF1_9ABC_5678_1234;
   localparam logic [7:0] SSEC = 8'h80;
   localparam logic [7:0] SPROT = 8'hFF;
   logic mclk;
   logic rst_n;
   logic rwr, rrd, awr, ard, stp, dbg, ssc, irq_o, stl;
   logic [2:0] radr;
   logic [7:0] rdat, rsp_r;
   logic [15:0] aadr, adat, rsp_a;
   int num_errors = 0;
   int check_count = 0;
   fsm_if bus();
   fsm_flash_ctrl #(.CMD_CYCLES(CYC), .KEY_W0(KEYS[15:0]),
      .KEY_W1(KEYS[31:16]), .KEY_W2(KEYS[47:32]), .KEY_W3(KEYS[63:48]),
      .STORED_SECURITY(SSEC), .STORED_PROT(SPROT)
   ) fsm_flash_ctrl_i (.mclk(mclk), .rst_n(rst_n), .bus(bus));
   fsm_cpu_end fsm_cpu_end_i (
      .mclk(mclk), .rst_n(rst_n), .bus(bus), .req_reg_wr(rwr),
      .req_reg_rd(rrd), .req_reg_addr(radr), .req_reg_wdata(rdat),
      .req_arr_wr(awr), .req_arr_rd(ard), .req_arr_addr(aadr),
      .req_arr_wdata(adat), .req_stop(stp), .req_debug(dbg),
      .req_ssc(ssc), .rsp_reg_rdata(rsp_r), .rsp_arr_rdata(rsp_a),
      .rsp_irq(irq_o), .rsp_stalled(stl)
   );
   fsm_checker #(.STORED_PROT(SPROT)) fsm_checker_i (
      .mclk(mclk), .rst_n(rst_n), .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd),
      .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata),
      .reg_rdata(bus.reg_rdata), .arr_wr(bus.arr_wr), .arr_rd(bus.arr_rd),
      .arr_rdata(bus.arr_rdata), .stop_mode(bus.stop_mode),
      .debug_mode(bus.debug_mode), .cpu_stall(bus.cpu_stall), .irq(bus.irq)
   );
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ****************************************************************
   // Access tasks.
   // ****************************************************************
   task automatic test_done();
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk);
      rwr = 1'b1;
      radr = a;
      rdat = d;
      @(negedge mclk);
      rwr = 1'b0;
   endtask
   task automatic rreg(input logic [2:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      @(negedge mclk);
      rrd = 1'b1;
      radr = a;
      @(negedge mclk);
      rrd = 1'b0;
      repeat (3) @(negedge mclk);
      chk({8'h00, rsp_r & m}, {8'h00, e});
   endtask
   task automatic warr(input logic [15:0] a, input logic [15:0] d);
      @(negedge mclk);
      awr = 1'b1;
      aadr = a;
      adat = d;
      @(negedge mclk);
      awr = 1'b0;
   endtask
   task automatic rarr(input logic [15:0] a, input logic [15:0] e);
      @(negedge mclk);
      ard = 1'b1;
      aadr = a;
      @(negedge mclk);
      ard = 1'b0;
      repeat (3) @(negedge mclk);
      chk(rsp_a, e);
   endtask
   task automatic do_reset();
      int n;
      n = 0;
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (8) @(negedge mclk);
      rst_n = 1'b1;
      repeat (2) @(negedge mclk);
      while (stl !== 1'b0 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      if (n == 50) begin
         num_errors++;
         test_done();
      end
   endtask
   task automatic launch(input logic [7:0] c);
      wreg(FSM_OFF_CMD, c);
      wreg(FSM_OFF_STAT, 8'h80);
   endtask
   task automatic key_try(input int f);
      logic [15:0] a, d;
      wreg(FSM_OFF_CNFG, 8'h20);
      for (int i = 0; i < 4; i++) begin
         a = FSM_ADDR_KEY0 + 16'(2 * i);
         d = KEYS[16 * i +: 16];
         if (f == 1 && i == 1) d = d ^ 16'h0001;
         if (f == 2 && i == 1) a = a + 16'h0002;
         if (f == 3 && i == 1) d = FSM_KEY_ZERO;
         if (f == 4 && i == 1) d = FSM_KEY_ONES;
         if (f == 5 && i == 2) break;
         warr(a, d);
      end
      if (f == 6) warr(FSM_ADDR_KEY0, KEYS[15:0]);
      wreg(FSM_OFF_CNFG, 8'h00);
   endtask
   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   initial begin
      {rwr, rrd, awr, ard, stp, dbg, ssc} = 7'h00;
      radr = 3'h0;
      rdat = 8'h00;
      aadr = 16'h0000;
      adat = 16'h0000;
      rst_n = 1'b0;
      do_reset();
      rreg(FSM_OFF_SECURITY, 8'hFF, SSEC);
      rreg(FSM_OFF_STAT, 8'hD0, 8'hC0);
      wreg(FSM_OFF_PROT, 8'h0F);
      rreg(FSM_OFF_PROT, 8'hFF, SPROT);
      dbg = 1'b1;
      wreg(FSM_OFF_PROT, 8'h0F);
      rreg(FSM_OFF_PROT, 8'hFF, 8'h0F);
      wreg(FSM_OFF_PROT, SPROT);
      dbg = 1'b0;
      $display("test reset_and_protection done");
      ssc = 1'b1;
      launch(8'h20);
      rreg(FSM_OFF_STAT, 8'h50, 8'h50);
      launch(FSM_CMD_MASS);
      rreg(FSM_OFF_STAT, 8'h50, 8'h50);
      wreg(FSM_OFF_STAT, 8'h10);
      launch(FSM_CMD_MASS);
      rreg(FSM_OFF_STAT, 8'hD0, 8'h00);
      repeat (CYC) @(negedge mclk);
      rreg(FSM_OFF_STAT, 8'hD0, 8'hC0);
      ssc = 1'b0;
      $display("test secured_commands done");
      wreg(FSM_OFF_CNFG, 8'hC0);
      launch(8'h20);
      repeat (5) @(negedge mclk);
      chk({15'h0000, irq_o}, 16'h0000);
      stp = 1'b1;
      rreg(FSM_OFF_STAT, 8'h50, 8'h50);
      chk({15'h0000, irq_o}, 16'h0001);
      stp = 1'b0;
      repeat (CYC) @(negedge mclk);
      rreg(FSM_OFF_STAT, 8'hD0, 8'hD0);
      wreg(FSM_OFF_STAT, 8'h10);
      rreg(FSM_OFF_STAT, 8'hD0, 8'hC0);
      wreg(FSM_OFF_CNFG, 8'h00);
      repeat (5) @(negedge mclk);
      chk({15'h0000, irq_o}, 16'h0000);
      launch(8'h20);
      do_reset();
      rreg(FSM_OFF_STAT, 8'hD0, 8'hC0);
      $display("test stop_and_abort done");
      rarr(16'h1000, 16'h1000);
      wreg(FSM_OFF_CNFG, 8'h20);
      rarr(16'h1000, FSM_BAD_DATA);
      wreg(FSM_OFF_CNFG, 8'h00);
      key_try(0);
      rreg(FSM_OFF_SECURITY, 8'h03, FSM_SECURITY_OPEN);
      rreg(FSM_OFF_SECURITY, 8'hC0, SSEC & 8'hC0);
      warr(FSM_ADDR_SECURITY, 16'h00FE);
      rreg(FSM_OFF_SECURITY, 8'hFF, {SSEC[7:2], FSM_SECURITY_OPEN});
      do_reset();
      rreg(FSM_OFF_SECURITY, 8'hFF, SSEC);
      for (int f = 1; f <= 6; f++) begin
         do_reset();
         key_try(f);
         rreg(FSM_OFF_SECURITY, 8'h03, SSEC & 8'h03);
         key_try(0);
         rreg(FSM_OFF_SECURITY, 8'h03, SSEC & 8'h03);
      end
      do_reset();
      dbg = 1'b1;
      ssc = 1'b1;
      key_try(0);
      rreg(FSM_OFF_SECURITY, 8'h03, SSEC & 8'h03);
      dbg = 1'b0;
      ssc = 1'b0;
      $display("test backdoor_key done");
      test_done();
   end
endmodule // flash_security_and_mode_control_tb
